/* hdl/sfb_params.svh */
// constants of the serial flash bus front end
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH

// ==========================================================
// array geometry
`define SFB_ADDR_W 25
`define SFB_BLOCK_LSB 16
`define SFB_SECTOR_LSB 12
`define SFB_LAST_BLOCK 9'h1ff
`define SFB_FIRST_BLOCK 9'h000
`define SFB_LOCK_DEPTH 544
`define SFB_LOCK_IDX_W 10
`define SFB_LOW_SECT_BASE 10'h200
`define SFB_HIGH_SECT_BASE 10'h210

// ==========================================================
// hold is dropped while quad mode owns the pin (16-pin package)
`define SFB_HOLD_QUAD_OFF 1'b1

// ==========================================================
// opcodes that read back data
`define SFB_OP_READ 8'h03
`define SFB_OP_FREAD 8'h0b
`define SFB_OP_RDID 8'h9f
`define SFB_OP_RDSR 8'h05
`define SFB_OP_SFDP 8'h5a
`define SFB_OP_RES 8'hab
`define SFB_OP_REMS 8'h90
// opcodes that must end on a byte boundary
`define SFB_OP_WREN 8'h06
`define SFB_OP_WRDI 8'h04
`define SFB_OP_WRSR 8'h01
`define SFB_OP_PP 8'h02
`define SFB_OP_SE 8'h20
`define SFB_OP_BE 8'hd8
`define SFB_OP_BE32 8'h52
`define SFB_OP_CE1 8'h60
`define SFB_OP_CE2 8'hc7
`define SFB_OP_DP 8'hb9

`endif

/* hdl/sfb_pkg.sv */
// types of the serial flash bus front end
package sfb_pkg;

    // ======================================================
    // interface state
    typedef enum logic [1:0] {
        SFB_IDLE    = 2'b00,
        SFB_OPCODE  = 2'b01,
        SFB_ACTIVE  = 2'b10,
        SFB_STANDBY = 2'b11
    } sfb_state_t;

    // command class
    typedef enum logic [1:0] {
        SFB_KIND_BAD   = 2'b00,
        SFB_KIND_READ  = 2'b01,
        SFB_KIND_WRITE = 2'b10
    } sfb_kind_t;

    // ======================================================
    // pin group seen from the host side
    typedef struct packed {
        logic sclk;
        logic csN;
        logic si;
        logic holdN;
    } sfb_pin_t;

    // one-cycle events towards the command core
    typedef struct packed {
        logic cmdStart;
        logic byteValid;
        logic exec;
        logic reject;
    } sfb_evt_t;

    // whole state of the front end
    typedef struct packed {
        sfb_pin_t pinS1;
        sfb_pin_t pinS2;
        logic sclkD;
        logic csD;
        sfb_state_t state;
        sfb_kind_t kind;
        logic hold;
        logic drive;
        logic [7:0] shiftIn;
        logic [2:0] bitCnt;
        logic [7:0] opcode;
        logic [7:0] rxByte;
        logic [7:0] txShift;
        logic soBit;
        logic soOe;
        logic txTake;
        sfb_evt_t evt;
    } sfb_regs_t;

endpackage

/* hdl/sfb_lock_mem.sv */
// lock bit memory with registered read port
`timescale 1ns/100ps
`include "sfb_params.svh"

module sfb_lock_mem (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // write port
    input wire logic wrEn,
    input wire logic [`SFB_LOCK_IDX_W-1:0] wrIdx,
    input wire logic wrData,
    // read port
    input wire logic [`SFB_LOCK_IDX_W-1:0] rdIdx,
    output logic rdData
);

    // ======================================================
    // storage, one bit per lock unit
    logic mem [0:`SFB_LOCK_DEPTH-1];

    // array has no reset: power-up lock state is up to the core
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrIdx] <= wrData;
        end
    end

    // read data comes from a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData <= 1'b0;
        end else begin
            rdData <= mem[rdIdx];
        end
    end

endmodule

/* hdl/sfb_frontend.sv */
// serial flash bus front end: framing, edges, hold and lock map
//
// Contract
// - bad opcode: standby until select rises
// - standby keeps serial output released
// - good opcode: active until select rises
// - input bits taken on clock rise
// - output bits changed on clock fall
// - clock modes 0 and 3 both work
// - reads may end after any output bit
// - writes must end on byte boundary
// - array access ignored while core busy
// - pause low suspends serial communication
// - pause never stops internal write work
// - pause starts only with clock low
// - pause ends only with clock low
// - pause releases output, ignores data, clock
// - select rise during pause resets interface
// - pause disabled during quad mode
// - general array locks per 64K block
// - chip erase only with protect level zero
`timescale 1ns/100ps
`include "sfb_params.svh"

module sfb_frontend (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial pins, asynchronous to clk
    input wire logic sclk,
    input wire logic csN,
    input wire logic siIn,
    input wire logic holdN,
    output logic soOut,
    output logic soOe,
    // status from the command core
    input wire logic busy,
    input wire logic quadActive,
    input wire logic [3:0] protectLevel,
    // transmit data from the command core
    input wire logic txEnable,
    input wire logic [7:0] txByte,
    output logic txTake,
    // received data towards the command core
    output sfb_pkg::sfb_evt_t evt,
    output logic [7:0] opcode,
    output logic [7:0] rxByte,
    output logic cmdActive,
    output logic holdActive,
    // lock map access
    input wire logic lockWrEn,
    input wire logic lockWrVal,
    input wire logic [`SFB_ADDR_W-1:0] lockAddr,
    input wire logic [`SFB_ADDR_W-1:0] lockQueryAddr,
    output logic locked
);

    // ======================================================
    // helper functions

    // command class of an opcode
    function automatic sfb_pkg::sfb_kind_t classify(
        input logic [7:0] op
    );
        sfb_pkg::sfb_kind_t k;
        k = sfb_pkg::SFB_KIND_BAD;
        case (op)
            `SFB_OP_READ, `SFB_OP_FREAD, `SFB_OP_RDID,
            `SFB_OP_RDSR, `SFB_OP_SFDP, `SFB_OP_RES,
            `SFB_OP_REMS: begin
                k = sfb_pkg::SFB_KIND_READ;
            end
            `SFB_OP_WREN, `SFB_OP_WRDI, `SFB_OP_WRSR,
            `SFB_OP_PP, `SFB_OP_SE, `SFB_OP_BE,
            `SFB_OP_BE32, `SFB_OP_CE1, `SFB_OP_CE2,
            `SFB_OP_DP: begin
                k = sfb_pkg::SFB_KIND_WRITE;
            end
            default: begin
                k = sfb_pkg::SFB_KIND_BAD;
            end
        endcase
        return k;
    endfunction

    // opcodes that touch the memory array
    function automatic logic isArrayOp(input logic [7:0] op);
        logic a;
        a = 1'b0;
        case (op)
            `SFB_OP_READ, `SFB_OP_FREAD, `SFB_OP_PP,
            `SFB_OP_SE, `SFB_OP_BE, `SFB_OP_BE32,
            `SFB_OP_CE1, `SFB_OP_CE2: begin
                a = 1'b1;
            end
            default: begin
                a = 1'b0;
            end
        endcase
        return a;
    endfunction

    // byte address to lock unit index
    function automatic logic [`SFB_LOCK_IDX_W-1:0] lockIndex(
        input logic [`SFB_ADDR_W-1:0] addr
    );
        logic [8:0] blk;
        logic [3:0] sect;
        logic [`SFB_LOCK_IDX_W-1:0] idx;
        blk = addr[`SFB_ADDR_W-1:`SFB_BLOCK_LSB];
        sect = addr[`SFB_BLOCK_LSB-1:`SFB_SECTOR_LSB];
        idx = {1'b0, blk};
        if (blk == `SFB_FIRST_BLOCK) begin
            idx = `SFB_LOW_SECT_BASE | {6'h00, sect};
        end else if (blk == `SFB_LAST_BLOCK) begin
            idx = `SFB_HIGH_SECT_BASE | {6'h00, sect};
        end
        return idx;
    endfunction

    // ======================================================
    // state registers
    sfb_pkg::sfb_regs_t r; // current state
    sfb_pkg::sfb_regs_t next_r; // next state

    // pin view after the synchroniser, named for reading
    logic sclkNow; // synchronised serial clock
    logic csLow; // select asserted, synchronised
    logic siNow; // synchronised serial input
    logic holdLow; // pause pin asserted
    logic sclkRise; // clock rising edge seen
    logic sclkFall; // clock falling edge seen
    logic csFall; // select falling edge seen
    logic csRise; // select rising edge seen
    logic holdEnable; // pause usable in this mode
    logic live; // edges are being obeyed
    sfb_pkg::sfb_kind_t newKind; // class of the byte just in
    logic newArray; // that byte is an array command
    logic [7:0] newByte; // byte completed at this edge

    // ======================================================
    // edge detection on the second synchroniser stage
    always_comb begin
        sclkNow = r.pinS2.sclk;
        csLow = !r.pinS2.csN;
        siNow = r.pinS2.si;
        holdLow = !r.pinS2.holdN;
        sclkRise = !r.sclkD && sclkNow;
        sclkFall = r.sclkD && !sclkNow;
        csFall = r.csD && csLow;
        csRise = !r.csD && !csLow;
        holdEnable = !(`SFB_HOLD_QUAD_OFF && quadActive);
        live = csLow && !r.hold;
        newByte = {r.shiftIn[6:0], siNow};
        newKind = classify(newByte);
        newArray = isArrayOp(newByte);
    end

    // ======================================================
    // next state
    always_comb begin
        next_r = r;
        // pulses last one cycle
        next_r.evt = '0;
        next_r.txTake = 1'b0;

        // two-stage synchroniser, third stage for edges
        next_r.pinS1.sclk = sclk;
        next_r.pinS1.csN = csN;
        next_r.pinS1.si = siIn;
        next_r.pinS1.holdN = holdN;
        next_r.pinS2 = r.pinS1;
        next_r.sclkD = r.pinS2.sclk;
        next_r.csD = r.pinS2.csN;

        // pause tracking, level based so a deferred
        // edge is taken as soon as the clock is low
        if (!csLow || !holdEnable) begin
            next_r.hold = 1'b0;
        end else if (!sclkNow) begin
            if (holdLow) begin
                next_r.hold = 1'b1;
            end else begin
                next_r.hold = 1'b0;
            end
        end
        // busy work is not touched by pause

        if (csRise) begin
            // select released: frame over
            if (r.hold) begin
                next_r.evt.reject = (r.state == sfb_pkg::SFB_ACTIVE)
                    && (r.kind == sfb_pkg::SFB_KIND_WRITE);
            end else if (r.state == sfb_pkg::SFB_ACTIVE &&
                         r.kind == sfb_pkg::SFB_KIND_WRITE) begin
                if (r.bitCnt == 3'h0) begin
                    next_r.evt.exec = 1'b1;
                end else begin
                    next_r.evt.reject = 1'b1;
                end
            end
            next_r.state = sfb_pkg::SFB_IDLE;
            next_r.drive = 1'b0;
            next_r.bitCnt = 3'h0;
        end else if (csFall) begin
            next_r.state = sfb_pkg::SFB_OPCODE;
            next_r.kind = sfb_pkg::SFB_KIND_BAD;
            next_r.drive = 1'b0;
            next_r.bitCnt = 3'h0;
        end else if (live && sclkRise) begin
            // mode 3 start fall is harmless here
            case (r.state)
                sfb_pkg::SFB_OPCODE: begin
                    next_r.shiftIn = newByte;
                    next_r.bitCnt = r.bitCnt + 3'h1;
                    if (r.bitCnt == 3'h7) begin
                        if (newKind == sfb_pkg::SFB_KIND_BAD) begin
                            next_r.state = sfb_pkg::SFB_STANDBY;
                            next_r.evt.reject = 1'b1;
                        end else if (newArray && busy) begin
                            next_r.state = sfb_pkg::SFB_STANDBY;
                            next_r.evt.reject = 1'b1;
                        end else if ((newByte == `SFB_OP_CE1 ||
                                      newByte == `SFB_OP_CE2) &&
                                     protectLevel != 4'h0) begin
                            next_r.state = sfb_pkg::SFB_STANDBY;
                            next_r.evt.reject = 1'b1;
                        end else begin
                            next_r.state = sfb_pkg::SFB_ACTIVE;
                            next_r.kind = newKind;
                            next_r.opcode = newByte;
                            next_r.evt.cmdStart = 1'b1;
                        end
                    end
                end
                sfb_pkg::SFB_ACTIVE: begin
                    next_r.shiftIn = newByte;
                    next_r.bitCnt = r.bitCnt + 3'h1;
                    if (r.bitCnt == 3'h7) begin
                        next_r.rxByte = newByte;
                        next_r.evt.byteValid = 1'b1;
                    end
                end
                sfb_pkg::SFB_STANDBY: begin
                    next_r.state = sfb_pkg::SFB_STANDBY;
                end
                default: begin
                    next_r.state = r.state;
                end
            endcase
        end else if (live && sclkFall) begin
            if (r.state == sfb_pkg::SFB_ACTIVE &&
                r.kind == sfb_pkg::SFB_KIND_READ && txEnable) begin
                next_r.drive = 1'b1;
                if (r.bitCnt == 3'h0) begin
                    // fresh byte at each boundary
                    next_r.soBit = txByte[7];
                    next_r.txShift = {txByte[6:0], 1'b0};
                    next_r.txTake = 1'b1;
                end else begin
                    next_r.soBit = r.txShift[7];
                    next_r.txShift = {r.txShift[6:0], 1'b0};
                end
            end
        end

        // output released in standby or pause
        next_r.soOe = next_r.drive && !next_r.hold &&
            (next_r.state == sfb_pkg::SFB_ACTIVE);
    end

    // ======================================================
    // state register; select and pause idle high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
            r.pinS1.csN <= 1'b1;
            r.pinS1.holdN <= 1'b1;
            r.pinS2.csN <= 1'b1;
            r.pinS2.holdN <= 1'b1;
            r.csD <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ======================================================
    // lock map, one memory for blocks and end sectors
    sfb_lock_mem lockMem (
        .clk(clk),
        .resetn(resetn),
        .wrEn(lockWrEn),
        .wrIdx(lockIndex(lockAddr)),
        .wrData(lockWrVal),
        .rdIdx(lockIndex(lockQueryAddr)),
        .rdData(locked)
    );

    // ======================================================
    // outputs from flops, except cmdActive, which is decoded from the state flops
    assign soOut = r.soBit;
    assign soOe = r.soOe;
    assign txTake = r.txTake;
    assign evt = r.evt;
    assign opcode = r.opcode;
    assign rxByte = r.rxByte;
    assign cmdActive = (r.state == sfb_pkg::SFB_ACTIVE);
    assign holdActive = r.hold;

endmodule

/* testbench/sfb_frontend_asserts.sv */
// assertion checker of the serial flash bus front end
`timescale 1ns/100ps
module sfb_frontend_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial pins
    input wire logic sclk,
    input wire logic csN,
    input wire logic holdN,
    input wire logic soOut,
    input wire logic soOe,
    // core side
    input wire logic busy,
    input wire logic quadActive,
    input wire logic [3:0] protectLevel,
    input wire logic [7:0] txByte,
    input wire logic txTake,
    input wire sfb_pkg::sfb_evt_t evt,
    input wire logic [7:0] opcode,
    input wire logic cmdActive,
    input wire logic holdActive
);
    // one clock domain, so clocking and disable are given once
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ==========================================================
    // framing and refusals
    chk_out_needs_active: assert property (soOe |-> cmdActive)
        else $error("serial out driven outside active state");
    chk_start_active: assert property (evt.cmdStart |-> cmdActive)
        else $error("opcode accepted without active state");
    chk_rise_ends: assert property ($rose(csN) |-> ##[1:6] !cmdActive)
        else $error("active state outlived select rise");
    chk_reject_alone: assert property (
        evt.reject |-> !evt.exec && !evt.cmdStart)
        else $error("refused command also executed");
    chk_busy_refuse: assert property (
        evt.cmdStart && busy |-> !(opcode inside {8'h03, 8'h0b,
        8'h02, 8'h20, 8'hd8, 8'h52, 8'h60, 8'hc7}))
        else $error("array command accepted while busy");
    chk_erase_guard: assert property (
        evt.exec && (opcode == 8'h60 || opcode == 8'hc7)
        |-> protectLevel == 4'h0)
        else $error("chip erase run with protect bits set");

    // ==========================================================
    // output shifting
    chk_shift_on_fall: assert property (
        soOe && $past(soOe) && $changed(soOut) |-> !$past(sclk, 3))
        else $error("serial out changed away from a clock fall");
    // a load that meets pause entry is kept but not driven yet
    chk_load_msb: assert property (
        txTake |-> soOe != holdActive && soOut == $past(txByte[7]))
        else $error("loaded byte does not start with its top bit");

    // ==========================================================
    // pause
    chk_hold_quiet: assert property (
        holdActive && $past(holdActive) |-> !soOe)
        else $error("serial out driven during pause");
    chk_hold_entry: assert property (
        $rose(holdActive)
        |-> !$past(sclk, 3) && !$past(holdN, 3) && !$past(csN, 3))
        else $error("pause began without clock low and select low");
    chk_hold_exit: assert property (
        $fell(holdActive) |-> !$past(sclk, 3) || $past(csN, 3))
        else $error("pause ended with clock high");
    chk_quad_no_hold: assert property (quadActive [*8] |-> !holdActive)
        else $error("pause taken in quad mode");
endmodule

bind sfb_frontend sfb_frontend_asserts chk (
    .clk(clk), .resetn(resetn), .sclk(sclk), .csN(csN), .holdN(holdN),
    .soOut(soOut), .soOe(soOe), .busy(busy), .quadActive(quadActive),
    .protectLevel(protectLevel), .txByte(txByte), .txTake(txTake),
    .evt(evt), .opcode(opcode), .cmdActive(cmdActive),
    .holdActive(holdActive)
);

/* testbench/sfb_host_model.sv */
// model of the serial host that drives the front end pins
`timescale 1ns/100ps
module sfb_host_model (
    // pins driven towards the device
    output logic sclk,
    output logic csN,
    output logic siIn,
    output logic holdN,
    // pin read back from the device
    input wire logic soOut,
    input wire logic soOe
);
    // idle: deselected, no pause, clock low
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        siIn = 1'b0;
        holdN = 1'b1;
    end

    // clock idles at the level of the mode
    task automatic begin_frame(input logic pol);
        sclk = pol;
        #40 csN = 1'b0;
        #80;
    endtask

    // data set at the fall, taken by both sides at the rise
    task automatic xfer(input logic [7:0] tx, input int nb,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nb; i++) begin
            sclk = 1'b0;
            siIn = tx[7 - i];
            #80 sclk = 1'b1;
            // a released line has no pull, so it reads inverted
            rx[7 - i] = soOe ? soOut : ~soOut;
            #80;
        end
    endtask

    // select rise; data line no longer holds its value
    task automatic end_frame(input logic pol);
        sclk = pol;
        #40 csN = 1'b1;
        siIn = ~siIn;
        #120;
    endtask

    // clock and pause pins moved, data scrambled meanwhile
    task automatic step(input logic clkv, input logic holdv);
        sclk = clkv;
        holdN = holdv;
        siIn = ~siIn;
        #80;
    endtask
endmodule

/* testbench/sfb_frontend_test.sv */
// self-checking bench of the serial flash bus front end
`timescale 1ns/100ps
`include "sfb_params.svh"
module sfb_frontend_test;
    // clock, reset and core side stimulus
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic busy = 1'b0;
    logic quadActive = 1'b0;
    logic [3:0] protectLevel = 4'h0;
    logic txEnable = 1'b0;
    logic [7:0] txByte = 8'h00;
    logic lockWrEn = 1'b0;
    logic lockWrVal = 1'b0;
    logic [`SFB_ADDR_W-1:0] lockAddr = '0;
    logic [`SFB_ADDR_W-1:0] lockQueryAddr = '0;
    // pins and design outputs
    logic sclk, csN, siIn, holdN, soOut, soOe, txTake;
    sfb_pkg::sfb_evt_t evt;
    logic [7:0] opcode, rxByte;
    logic cmdActive, holdActive, locked;
    // event tallies and verdict counters
    int nStart, nExec, nRej;
    int badCount = 0;
    int checks = 0;

    // 125 MHz system clock
    always #4 clk = ~clk;

    // tally one-cycle events
    always @(posedge clk) begin
        if (evt.cmdStart === 1'b1) nStart++;
        if (evt.exec === 1'b1) nExec++;
        if (evt.reject === 1'b1) nRej++;
    end

    sfb_frontend dut (.clk(clk), .resetn(resetn), .sclk(sclk), .csN(csN),
        .siIn(siIn), .holdN(holdN), .soOut(soOut), .soOe(soOe),
        .busy(busy), .quadActive(quadActive), .protectLevel(protectLevel),
        .txEnable(txEnable), .txByte(txByte), .txTake(txTake), .evt(evt),
        .opcode(opcode), .rxByte(rxByte), .cmdActive(cmdActive),
        .holdActive(holdActive), .lockWrEn(lockWrEn), .lockWrVal(lockWrVal),
        .lockAddr(lockAddr), .lockQueryAddr(lockQueryAddr), .locked(locked));
    sfb_host_model host (.sclk(sclk), .csN(csN), .siIn(siIn),
        .holdN(holdN), .soOut(soOut), .soOe(soOe));

    // ==========================================================
    // shared helpers
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d badCount=%0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // whole frame; exp packs start, exec and reject tallies (2 bits each)
    task automatic frame(input logic [7:0] op, input int extra,
                         input logic pol, input logic [7:0] exp);
        logic [7:0] rx;
        nStart = 0;
        nExec = 0;
        nRej = 0;
        host.begin_frame(pol);
        host.xfer(op, 8, rx);
        cmp1(cmdActive, exp[4]);
        // extra bits carry a valid opcode, so a standby leak shows up
        for (int i = 0; i < extra; i += 8) begin
            host.xfer(8'h06, (extra - i > 8) ? 8 : extra - i, rx);
        end
        host.end_frame(pol);
        cmp8({2'b00, 2'(nStart), 2'(nExec), 2'(nRej)}, exp);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_write();
        logic [7:0] ops [10] = '{8'h06, 8'h04, 8'h01, 8'h02, 8'h20,
                                 8'hd8, 8'h52, 8'h60, 8'hc7, 8'hb9};
        for (int i = 0; i < 10; i++) begin
            frame(ops[i], 8 * (i % 4), i[0], 8'h14);
        end
    endtask
    task automatic t_refuse();
        frame(8'h06, 3, 1'b0, 8'h11);
        frame(8'h02, 13, 1'b1, 8'h11);
        frame(8'hff, 16, 1'b0, 8'h01);
        frame(8'h3b, 8, 1'b1, 8'h01);
        frame(8'h06, 0, 1'b1, 8'h14);
    endtask
    task automatic t_busy();
        tick();
        busy = 1'b1;
        frame(8'h03, 32, 1'b0, 8'h01);
        frame(8'hd8, 32, 1'b1, 8'h01);
        // status polled while the core is busy
        frame(8'h05, 8, 1'b0, 8'h10);
        tick();
        busy = 1'b0;
        // each protect bit alone must block a chip erase
        for (int i = 0; i < 4; i++) begin
            protectLevel = 4'h1 << i;
            frame(8'h60, 0, i[0], 8'h01);
            frame(8'hc7, 0, i[1], 8'h01);
        end
        tick();
        protectLevel = 4'h0;
    endtask
    task automatic t_read();
        logic [7:0] ops [7] = '{8'h03, 8'h0b, 8'h9f, 8'h05, 8'h5a,
                                8'hab, 8'h90};
        logic [7:0] rx;
        for (int i = 0; i < 7; i++) begin
            tick();
            txEnable = 1'b1;
            txByte = ~ops[i];
            host.begin_frame(i[0]);
            host.xfer(ops[i], 8, rx);
            cmp8(opcode, ops[i]);
            host.xfer(ops[i], 8, rx);
            cmp8(rx, ~ops[i]);
            cmp8(rxByte, ops[i]);
            cmp1(soOe, 1'b1);
            host.xfer(8'h00, 3, rx);
            host.end_frame(i[0]);
            cmp1(soOe, 1'b0);
        end
    endtask
    task automatic t_pause();
        logic [7:0] hi, lo;
        tick();
        txByte = 8'h5c;
        host.begin_frame(1'b0);
        host.xfer(8'h9f, 8, hi);
        host.xfer(8'h00, 4, hi);
        host.step(1'b0, 1'b1);
        host.step(1'b0, 1'b0);
        cmp1(holdActive, 1'b1);
        cmp1(soOe, 1'b0);
        host.step(1'b1, 1'b0);
        host.step(1'b0, 1'b0);
        host.step(1'b0, 1'b1);
        cmp1(holdActive, 1'b0);
        host.xfer(8'h00, 4, lo);
        cmp8({hi[7:4], lo[7:4]}, 8'h5c);
        host.end_frame(1'b0);
        // deferred entry and exit, then select rise inside a pause
        host.begin_frame(1'b0);
        host.xfer(8'h9f, 8, hi);
        host.step(1'b1, 1'b0);
        cmp1(holdActive, 1'b0);
        host.step(1'b0, 1'b0);
        cmp1(holdActive, 1'b1);
        host.step(1'b1, 1'b1);
        cmp1(holdActive, 1'b1);
        host.step(1'b0, 1'b1);
        cmp1(holdActive, 1'b0);
        host.step(1'b0, 1'b0);
        host.end_frame(1'b0);
        cmp1(holdActive, 1'b0);
        cmp1(cmdActive, 1'b0);
        host.step(1'b0, 1'b1);
        frame(8'h06, 0, 1'b0, 8'h14);
    endtask
    task automatic t_quad();
        logic [7:0] rx;
        tick();
        quadActive = 1'b1;
        host.begin_frame(1'b0);
        host.xfer(8'h9f, 8, rx);
        host.step(1'b0, 1'b0);
        cmp1(holdActive, 1'b0);
        host.step(1'b0, 1'b1);
        host.end_frame(1'b0);
        tick();
        quadActive = 1'b0;
    endtask
    task automatic lock_wr(input logic [24:0] a, input logic v);
        tick();
        lockAddr = a;
        lockWrVal = v;
        lockWrEn = 1'b1;
        tick();
        lockWrEn = 1'b0;
    endtask
    task automatic lock_q(input logic [24:0] a, input logic v);
        tick();
        lockQueryAddr = a;
        tick();
        cmp1(locked, v);
    endtask
    task automatic t_lock();
        lock_wr(25'h0050000, 1'b1);
        lock_wr(25'h0060000, 1'b0);
        lock_wr(25'h0003000, 1'b1);
        lock_wr(25'h0004000, 1'b0);
        lock_wr(25'h1ffe000, 1'b1);
        lock_wr(25'h1fff000, 1'b0);
        lock_q(25'h005ffff, 1'b1);
        lock_q(25'h0060000, 1'b0);
        lock_q(25'h0003fff, 1'b1);
        lock_q(25'h0004000, 1'b0);
        lock_q(25'h1ffefff, 1'b1);
        lock_q(25'h1fff000, 1'b0);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (4) tick();
        t_write();
        t_refuse();
        t_busy();
        t_read();
        t_pause();
        t_quad();
        t_lock();
        end_sim();
    end
    initial begin
        #500us;
        badCount++;
        end_sim();
    end
endmodule
